// ### core/acs_pkg.sv
package acs_pkg;

  localparam int ACC_W   = 32;
  localparam int HALF_W  = 16;
  localparam int FLAG_W  = 8;
  localparam int ACC_NUM = 4;

  // Condition byte bit positions
  localparam int CC_HIGH_BIT   = 7;
  localparam int CC_LOW_BIT    = 6;
  localparam int OV_BIT        = 5;
  localparam int OS_BIT        = 4;
  localparam int OR_BIT        = 3;
  localparam int STA_BIT       = 2;
  localparam int RLO_BIT       = 1;
  localparam int FIRST_BIT     = 0;

  localparam logic [31:0] ACC_RESET  = 32'h0000_0000;
  localparam logic [7:0]  FLAG_RESET = 8'h00;

  // Result code encodings
  localparam logic [1:0] RC_ZERO = 2'h0;
  localparam logic [1:0] RC_NEG  = 2'h1;
  localparam logic [1:0] RC_POS  = 2'h2;
  localparam logic [1:0] RC_DIV0 = 2'h3;

  typedef enum logic [3:0] {
    ACS_NOP,
    ACS_LOAD,
    ACS_ADD,
    ACS_SUB,
    ACS_MUL,
    ACS_DIV,
    ACS_ADD16,
    ACS_SUB16,
    ACS_ADDK,
    ACS_BIT_AND,
    ACS_BIT_OR,
    ACS_BIT_SET,
    ACS_BIT_ORHELP,
    ACS_WRITE_FLAGS
  } acs_op_e;

  // Byte lane select for partial loads
  typedef enum logic [2:0] {
    ACS_LANE_WORD,
    ACS_LANE_HIGHWORD,
    ACS_LANE_LOWWORD,
    ACS_LANE_TOPBYTE,
    ACS_LANE_LOWBYTE
  } acs_lane_e;

endpackage : acs_pkg

// ### core/acs_ctx_if.sv
`timescale 1ns/100ps
interface acs_ctx_if;
  import acs_pkg::*;
  logic              save;
  logic              restore;
  logic [ACC_W-1:0]  accIn [ACC_NUM];
  logic [FLAG_W-1:0] flagsIn;
  logic [ACC_W-1:0]  accOut [ACC_NUM];
  logic [FLAG_W-1:0] flagsOut;
  logic              valid;

  modport core  (output save, output restore, output accIn, output flagsIn,
                 input accOut, input flagsOut, input valid);
  modport store (input save, input restore, input accIn, input flagsIn,
                 output accOut, output flagsOut, output valid);
endinterface : acs_ctx_if

// ### core/acs_context_store.sv
`timescale 1ns/100ps
module acs_context_store
  import acs_pkg::*;
(
  input wire logic  clk,
  input wire logic  sys_rst,
  acs_ctx_if.store  ctx
);
  import acs_pkg::*;

  // One save slot per nesting level would be larger; a single level is kept here
  logic [ACC_W-1:0]  savedAcc [ACC_NUM];
  logic [FLAG_W-1:0] savedFlags;
  logic              savedValid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < ACC_NUM; i++) savedAcc[i] <= ACC_RESET;
      savedFlags <= FLAG_RESET;
      savedValid <= 1'b0;
    end else if (ctx.save) begin
      for (int i = 0; i < ACC_NUM; i++) savedAcc[i] <= ctx.accIn[i]; // RULE15
      savedFlags <= ctx.flagsIn;
      savedValid <= 1'b1;
    end else if (ctx.restore) begin
      savedValid <= 1'b0;
    end
  end

  assign ctx.accOut   = savedAcc;
  assign ctx.flagsOut = savedFlags;
  assign ctx.valid    = savedValid;
endmodule : acs_context_store

// ### core/acs_accumulator_stack.sv
// Summary of operation
// RULE1: Four accumulators form a stack that shifts as a unit; the code never shifts all four, a load leaves the third and fourth.
// RULE2: Operands come from the first and second accumulators, each 32 bits, and results go to the first.
// RULE3: Each accumulator splits into high word 31..16 and low word 15..0, each in two bytes, alike for all four.
// RULE4: A load writes the first accumulator and pushes its old value into the second.
// RULE5: A load leaves the third and fourth accumulators unchanged.
// RULE6: Arithmetic writes its result to the first, then copies third to second and fourth to third.
// RULE7: In 16-bit arithmetic the drop moves only the low words and leaves high words alone.
// RULE8: Adding an immediate constant to the first leaves the other three untouched.
// RULE9: Flags sit in one byte, word flags in bits 7..4 and bit flags in bits 3..0.
// RULE10: Byte layout from bit 7: result code high, low, overflow, sticky overflow, or-helper, status, logic result, first scan.
// RULE11: The programming device reads the current flag byte through a status request.
// RULE12: A set/reset clears the first-scan flag; the next bit logic operation starts a new result.
// RULE13: The sticky overflow flag latches any overflow across later arithmetic.
// RULE14: Arithmetic result codes are 00 zero, 01 negative, 10 positive, 11 division by zero.
// RULE15: On a level change all accumulators and flags are saved and restored on return; the code keeps one saved level, which a nested change overwrites.
`timescale 1ns/100ps
module acs_accumulator_stack
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Operation from the sequencer
  input  wire logic              opValid,
  input  wire acs_pkg::acs_op_e  opCode,
  input  wire acs_pkg::acs_lane_e opLane,
  input  wire logic [31:0]       operand,
  input  wire logic              scanBit,
  input  wire logic              scanInvert,
  input  wire logic [7:0]        flagWrite,
  // Level change
  input  wire logic              levelEnter,
  input  wire logic              levelLeave,
  // Programming device status request
  input  wire logic              statusReq,
  output logic                   statusAck,
  output logic [7:0]             statusFlags,
  // Stack and flag view
  output logic [31:0]            primary_accumulator,
  output logic [31:0]            second_accumulator,
  output logic [31:0]            third_accumulator,
  output logic [31:0]            fourth_accumulator,
  output logic [7:0]             condition_flag_byte
);
  import acs_pkg::*;

  // Sign-aware zero/negative/positive encoding, used for 32- and 16-bit results
  function automatic logic [1:0] result_code(input logic [31:0] v, input logic isHalf);
    logic neg;
    logic zero;
    neg  = isHalf ? v[HALF_W-1] : v[ACC_W-1];
    zero = isHalf ? (v[HALF_W-1:0] == 16'h0000) : (v == 32'h0000_0000);
    if (zero) result_code = RC_ZERO;
    else if (neg) result_code = RC_NEG;
    else result_code = RC_POS;
  endfunction : result_code

  // Places a partial value into a word according to the lane
  function automatic logic [31:0] merge_lane(input logic [31:0] old, input logic [31:0] v,
                                             input acs_lane_e lane);
    merge_lane = old;
    unique case (lane)
      ACS_LANE_WORD:     merge_lane = v;
      ACS_LANE_HIGHWORD: merge_lane[31:16] = v[15:0];
      ACS_LANE_LOWWORD:  merge_lane[15:0] = v[15:0];
      ACS_LANE_TOPBYTE:  merge_lane[31:24] = v[7:0];
      ACS_LANE_LOWBYTE:  merge_lane[7:0] = v[7:0];
      default:           merge_lane = old;
    endcase
  endfunction : merge_lane

  logic [31:0] acc [ACC_NUM];
  logic [7:0]  flags;
  logic [31:0] next_acc [ACC_NUM];
  logic [7:0]  next_flags;

  acs_ctx_if ctx ();

  acs_context_store uStore (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ctx     (ctx.store)
  );

  assign ctx.save    = levelEnter; // RULE15
  assign ctx.restore = levelLeave & ctx.valid;
  assign ctx.accIn   = acc;
  assign ctx.flagsIn = flags;

  // Arithmetic datapath on first and second accumulators
  wire logic [31:0] a1 = acc[0];
  wire logic [31:0] a2 = acc[1];
  wire logic [32:0] sum32  = {a2[31], a2} + {a1[31], a1}; // RULE2
  wire logic [32:0] diff32 = {a2[31], a2} - {a1[31], a1};
  wire logic [16:0] sum16  = {a2[15], a2[15:0]} + {a1[15], a1[15:0]};
  wire logic [16:0] diff16 = {a2[15], a2[15:0]} - {a1[15], a1[15:0]};
  wire logic [32:0] sumK   = {a1[31], a1} + {operand[31], operand};
  wire logic [63:0] prod   = $signed(a2) * $signed(a1);
  wire logic        divZero = (a1 == ACC_RESET);
  // Division avoided when divisor is zero so no X propagates
  wire logic [31:0] quot   = divZero ? ACC_RESET : 32'($signed(a2) / $signed(a1));
  wire logic        divOv  = (a2 == 32'h8000_0000) && (a1 == 32'hFFFF_FFFF);
  wire logic        mulOv  = (prod[63:31] != {33{1'b0}}) && (prod[63:31] != {33{1'b1}});

  // Bit logic helpers
  wire logic scanned  = scanBit ^ scanInvert;
  wire logic firstOn  = flags[FIRST_BIT];
  wire logic rloAnd   = firstOn ? (flags[RLO_BIT] & scanned) : scanned; // RULE12
  wire logic rloOr    = firstOn ? (flags[RLO_BIT] | scanned) : scanned;

  always_comb begin
    logic [31:0] res;
    logic        ov;
    logic        half;
    logic        arith;
    res   = ACC_RESET;
    ov    = 1'b0;
    half  = 1'b0;
    arith = 1'b0;
    for (int i = 0; i < ACC_NUM; i++) next_acc[i] = acc[i];
    next_flags = flags;
    if (ctx.restore) begin
      for (int i = 0; i < ACC_NUM; i++) next_acc[i] = ctx.accOut[i]; // RULE15
      next_flags = ctx.flagsOut;
    end else if (opValid) begin
      unique case (opCode)
        ACS_NOP: ;
        ACS_LOAD: begin
          next_acc[0] = merge_lane(ACC_RESET, operand, opLane); // RULE4 RULE3
          next_acc[1] = acc[0]; // RULE4
          // Third and fourth hold RULE5
        end
        ACS_ADD: begin
          res = sum32[31:0];
          ov = sum32[32] ^ sum32[31];
          arith = 1'b1;
        end
        ACS_SUB: begin
          res = diff32[31:0];
          ov = diff32[32] ^ diff32[31];
          arith = 1'b1;
        end
        ACS_MUL: begin
          res = prod[31:0];
          ov = mulOv;
          arith = 1'b1;
        end
        ACS_DIV: begin
          res = quot;
          ov = divOv;
          arith = 1'b1;
        end
        ACS_ADD16: begin
          res = {a1[31:16], sum16[15:0]};
          ov = sum16[16] ^ sum16[15];
          half = 1'b1;
          arith = 1'b1;
        end
        ACS_SUB16: begin
          res = {a1[31:16], diff16[15:0]};
          ov = diff16[16] ^ diff16[15];
          half = 1'b1;
          arith = 1'b1;
        end
        ACS_ADDK: begin
          next_acc[0] = sumK[31:0]; // RULE8
          next_flags[OV_BIT] = sumK[32] ^ sumK[31];
          next_flags[OS_BIT] = flags[OS_BIT] | (sumK[32] ^ sumK[31]); // RULE13
          {next_flags[CC_HIGH_BIT], next_flags[CC_LOW_BIT]} = result_code(sumK[31:0], 1'b0);
        end
        ACS_BIT_AND: begin
          next_flags[RLO_BIT]   = rloAnd; // RULE12
          next_flags[STA_BIT]   = scanBit;
          next_flags[FIRST_BIT] = 1'b1;
        end
        ACS_BIT_OR: begin
          next_flags[RLO_BIT]   = rloOr | (firstOn & flags[OR_BIT]);
          next_flags[STA_BIT]   = scanBit;
          next_flags[FIRST_BIT] = 1'b1;
        end
        ACS_BIT_ORHELP: begin
          next_flags[OR_BIT] = flags[RLO_BIT] | flags[OR_BIT];
        end
        ACS_BIT_SET: begin
          next_flags[FIRST_BIT] = 1'b0; // RULE12
          next_flags[OR_BIT]    = 1'b0;
        end
        ACS_WRITE_FLAGS: next_flags = flagWrite; // RULE9
        default: ;
      endcase
      if (arith) begin
        next_acc[0] = res; // RULE6
        if (half) begin
          next_acc[1] = {acc[1][31:16], acc[2][15:0]}; // RULE7
          next_acc[2] = {acc[2][31:16], acc[3][15:0]}; // RULE7
        end else begin
          next_acc[1] = acc[2]; // RULE6
          next_acc[2] = acc[3]; // RULE6
        end
        next_flags[OV_BIT] = ov;
        next_flags[OS_BIT] = flags[OS_BIT] | ov; // RULE13
        if (opCode == ACS_DIV && divZero) begin
          {next_flags[CC_HIGH_BIT], next_flags[CC_LOW_BIT]} = RC_DIV0; // RULE14
        end else begin
          {next_flags[CC_HIGH_BIT], next_flags[CC_LOW_BIT]} = result_code(res, half); // RULE14
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < ACC_NUM; i++) acc[i] <= ACC_RESET; // RULE1
      flags <= FLAG_RESET;
    end else begin
      for (int i = 0; i < ACC_NUM; i++) acc[i] <= next_acc[i];
      flags <= next_flags;
    end
  end

  // Outputs registered from the same next values, so they track the stack exactly
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      primary_accumulator <= ACC_RESET;
      second_accumulator  <= ACC_RESET;
      third_accumulator   <= ACC_RESET;
      fourth_accumulator  <= ACC_RESET;
      condition_flag_byte <= FLAG_RESET;
    end else begin
      primary_accumulator <= next_acc[0];
      second_accumulator  <= next_acc[1];
      third_accumulator   <= next_acc[2];
      fourth_accumulator  <= next_acc[3];
      condition_flag_byte <= next_flags; // RULE10
    end
  end

  // Status snapshot of the byte as it stands when requested
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      statusAck   <= 1'b0;
      statusFlags <= FLAG_RESET;
    end else begin
      statusAck <= statusReq; // RULE11
      if (statusReq) statusFlags <= flags; // RULE11
    end
  end
endmodule : acs_accumulator_stack

// ### dv/acs_accumulator_stack_monitor.sv
`timescale 1ns/100ps
module acs_stack_monitor
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               sys_rst,
  // Sequencer side
  input wire logic               opValid,
  input wire acs_pkg::acs_op_e   opCode,
  input wire acs_pkg::acs_lane_e opLane,
  input wire logic [31:0]        operand,
  input wire logic               scanBit,
  input wire logic               scanInvert,
  input wire logic               levelLeave,
  // Status and stack
  input wire logic               statusReq,
  input wire logic               statusAck,
  input wire logic [7:0]         statusFlags,
  input wire logic [31:0]        primary_accumulator,
  input wire logic [31:0]        second_accumulator,
  input wire logic [31:0]        third_accumulator,
  input wire logic [31:0]        fourth_accumulator,
  input wire logic [7:0]         condition_flag_byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // A pending restore overrides the operation, so it is left out
  sequence issue(acs_op_e c);
    opValid && !levelLeave && opCode == c;
  endsequence
  sequence arith;
    opValid && !levelLeave && opCode inside {ACS_ADD, ACS_SUB, ACS_MUL, ACS_DIV};
  endsequence

  load_push_a: assert property (issue(ACS_LOAD) |=> second_accumulator == $past(primary_accumulator))
    else $error("load did not push the first accumulator");
  load_keep_a: assert property (issue(ACS_LOAD) |=> $stable(third_accumulator) && $stable(fourth_accumulator))
    else $error("load changed third or fourth accumulator");
  load_word_a: assert property (issue(ACS_LOAD) ##0 opLane == ACS_LANE_WORD |=> primary_accumulator == $past(operand))
    else $error("word load value wrong");
  stack_drop_a: assert property (arith |=> second_accumulator == $past(third_accumulator)
      && third_accumulator == $past(fourth_accumulator))
    else $error("stack drop wrong");
  add_sum_a: assert property (issue(ACS_ADD) |=> primary_accumulator
      == $past(second_accumulator) + $past(primary_accumulator))
    else $error("sum wrong");
  half_drop_a: assert property (opValid && !levelLeave && opCode inside {ACS_ADD16, ACS_SUB16} |=>
      second_accumulator == {$past(second_accumulator[31:16]), $past(third_accumulator[15:0])}
      && third_accumulator == {$past(third_accumulator[31:16]), $past(fourth_accumulator[15:0])})
    else $error("16-bit drop wrong");
  addk_keep_a: assert property (issue(ACS_ADDK) |=> $stable(second_accumulator) && $stable(third_accumulator)
      && $stable(fourth_accumulator))
    else $error("constant add moved the stack");
  sticky_hold_a: assert property (arith ##0 condition_flag_byte[OS_BIT] |=> condition_flag_byte[OS_BIT])
    else $error("sticky overflow lost");
  div_zero_a: assert property (issue(ACS_DIV) ##0 primary_accumulator == 32'h0000_0000 |=>
      condition_flag_byte[CC_HIGH_BIT:CC_LOW_BIT] == RC_DIV0)
    else $error("division by zero code wrong");
  seq_end_a: assert property (issue(ACS_BIT_SET) |=> !condition_flag_byte[FIRST_BIT])
    else $error("set did not end the sequence");
  fresh_scan_a: assert property (issue(ACS_BIT_AND) ##0 !condition_flag_byte[FIRST_BIT] |=>
      condition_flag_byte[FIRST_BIT] && condition_flag_byte[RLO_BIT] == $past(scanBit ^ scanInvert))
    else $error("first scan result wrong");
  status_ack_a: assert property (statusReq && !opValid && !levelLeave |=> statusAck
      && statusFlags == $past(condition_flag_byte))
    else $error("status answer wrong");
endmodule : acs_stack_monitor

// ### dv/acs_prog_device.sv
`timescale 1ns/100ps
module acs_prog_device (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Bench trigger
  input  wire logic       ask,
  // Status function
  output logic            statusReq,
  input  wire logic       statusAck,
  input  wire logic [7:0] statusFlags,
  // Captured byte
  output logic [7:0]      shownFlags
);
  // One request per trigger; the byte is only kept when the answer arrives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      statusReq  <= 1'b0;
      shownFlags <= 8'h00;
    end else begin
      statusReq <= ask && !statusReq;
      if (statusAck) begin
        shownFlags <= statusFlags;
      end
    end
  end
endmodule : acs_prog_device

// ### dv/acs_accumulator_stack_tb_top.sv
`timescale 1ns/100ps
module acs_accumulator_stack_tb_top;
  import acs_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        opValid = 1'b0;
  acs_op_e     opCode = ACS_NOP;
  acs_lane_e   opLane = ACS_LANE_WORD;
  logic [31:0] operand = 32'h0000_0000;
  logic        scanBit = 1'b0;
  logic        scanInvert = 1'b0;
  logic [7:0]  flagWrite = 8'h00;
  logic        levelEnter = 1'b0;
  logic        levelLeave = 1'b0;
  logic        ask = 1'b0;
  logic        statusReq, statusAck;
  logic [7:0]  statusFlags, shownFlags, flags;
  logic [31:0] pAcc, sAcc, tAcc, fAcc;
  int          errors = 0;
  int          nChecks = 0;
  int          cycles = 0;

  always #10 clk = ~clk;

  acs_accumulator_stack acs_accumulator_stack_inst (.clk(clk), .sys_rst(sys_rst), .opValid(opValid),
    .opCode(opCode), .opLane(opLane), .operand(operand), .scanBit(scanBit), .scanInvert(scanInvert),
    .flagWrite(flagWrite), .levelEnter(levelEnter), .levelLeave(levelLeave), .statusReq(statusReq),
    .statusAck(statusAck), .statusFlags(statusFlags), .primary_accumulator(pAcc),
    .second_accumulator(sAcc), .third_accumulator(tAcc), .fourth_accumulator(fAcc),
    .condition_flag_byte(flags));
  acs_prog_device acs_prog_device_inst (.clk(clk), .sys_rst(sys_rst), .ask(ask), .statusReq(statusReq),
    .statusAck(statusAck), .statusFlags(statusFlags), .shownFlags(shownFlags));

  task automatic wrap_up();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Wide enough for the packed groups of accumulators and flags compared at once
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Operations stay back to back until idle() drops the valid
  task automatic doOp(input acs_op_e c, input logic [31:0] v, input acs_lane_e l = ACS_LANE_WORD,
                      input logic sb = 1'b0, input logic si = 1'b0);
    @(negedge clk);
    opValid = 1'b1;
    opCode = c;
    opLane = l;
    operand = v;
    flagWrite = v[7:0];
    scanBit = sb;
    scanInvert = si;
  endtask : doOp

  task automatic idle();
    @(negedge clk);
    opValid = 1'b0;
  endtask : idle

  task automatic strobe(input logic [2:0] s);
    @(negedge clk);
    {levelEnter, levelLeave, ask} = s;
    @(negedge clk);
    {levelEnter, levelLeave, ask} = 3'b000;
  endtask : strobe

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk(pAcc, 32'h0000_0000);
    doOp(ACS_LOAD, 32'h1234_5678);
    doOp(ACS_LOAD, 32'h0000_00A5, ACS_LANE_TOPBYTE);
    idle();
    chk(pAcc, 32'hA500_0000);
    chk(sAcc, 32'h1234_5678);
    chk(tAcc | fAcc, 32'h0000_0000);
    doOp(ACS_LOAD, 32'h0000_BEEF, ACS_LANE_HIGHWORD);
    doOp(ACS_LOAD, 32'h1234_56C3, ACS_LANE_LOWBYTE);
    doOp(ACS_LOAD, 32'hCAFE_1234, ACS_LANE_LOWWORD);
    idle();
    chk({pAcc, sAcc}, {32'h0000_1234, 32'h0000_00C3});
    doOp(ACS_LOAD, 32'h0000_0003);
    doOp(ACS_LOAD, 32'h0000_000A);
    doOp(ACS_SUB, 32'h0000_0000);
    idle();
    chk({pAcc, sAcc, 6'h00, flags[7:6]}, {32'hFFFF_FFF9, 32'h0000_0000, 8'h01});
    doOp(ACS_LOAD, 32'h0000_0000);
    doOp(ACS_NOP, 32'hFFFF_FFFF);
    doOp(ACS_LOAD, 32'h0000_0000);
    doOp(ACS_ADD, 32'h0000_0000);
    idle();
    chk({pAcc, 6'h00, flags[7:6]}, {32'h0000_0000, 8'h00});
    doOp(ACS_LOAD, 32'h0000_0008);
    doOp(ACS_LOAD, 32'h0000_0000);
    doOp(ACS_DIV, 32'h0000_0000);
    idle();
    chk({pAcc, 6'h00, flags[7:6]}, {32'h0000_0000, 8'h03});
    doOp(ACS_LOAD, 32'h7FFF_FFFF);
    doOp(ACS_LOAD, 32'h0000_0001);
    doOp(ACS_ADD, 32'h0000_0000);
    idle();
    chk(flags[5:4], 2'h3);
    doOp(ACS_LOAD, 32'h0000_0006);
    doOp(ACS_LOAD, 32'h0000_0007);
    doOp(ACS_MUL, 32'h0000_0000);
    idle();
    chk({pAcc, 4'h0, flags[7:4]}, {32'h0000_002A, 8'h09});
    doOp(ACS_LOAD, 32'hAAAA_0003);
    doOp(ACS_LOAD, 32'h0000_0004);
    doOp(ACS_ADD16, 32'h0000_0000);
    idle();
    chk({pAcc, sAcc}, {32'h0000_0007, 32'hAAAA_0000});
    doOp(ACS_SUB16, 32'h0000_0000);
    doOp(ACS_LOAD, 32'h0000_0011);
    doOp(ACS_LOAD, 32'h0000_0022);
    doOp(ACS_ADDK, 32'h0000_0005);
    idle();
    chk({pAcc, sAcc}, {32'h0000_0027, 32'h0000_0011});
    doOp(ACS_BIT_SET, 32'h0000_0000);
    doOp(ACS_BIT_AND, 32'h0000_0000, ACS_LANE_WORD, 1'b0);
    doOp(ACS_BIT_OR, 32'h0000_0000, ACS_LANE_WORD, 1'b1);
    doOp(ACS_BIT_AND, 32'h0000_0000, ACS_LANE_WORD, 1'b1, 1'b1);
    idle();
    chk(flags[2:0], 3'h5);
    doOp(ACS_BIT_ORHELP, 32'h0000_0000);
    doOp(ACS_BIT_SET, 32'h0000_0000);
    doOp(ACS_BIT_AND, 32'h0000_0000, ACS_LANE_WORD, 1'b1);
    idle();
    chk(flags[1:0], 2'h3);
    doOp(ACS_WRITE_FLAGS, 32'h0000_005A);
    idle();
    chk(flags, 8'h5A);
    strobe(3'b001);
    repeat (3) @(negedge clk);
    chk(shownFlags, 8'h5A);
    doOp(ACS_LOAD, 32'h0000_0044);
    doOp(ACS_LOAD, 32'h0000_0055);
    idle();
    strobe(3'b100);
    doOp(ACS_LOAD, 32'h0000_0066);
    doOp(ACS_ADD, 32'h0000_0000);
    doOp(ACS_WRITE_FLAGS, 32'h0000_0000);
    idle();
    strobe(3'b010);
    chk({pAcc, sAcc, flags}, {32'h0000_0055, 32'h0000_0044, 8'h5A});
    wrap_up();
  end
endmodule : acs_accumulator_stack_tb_top

bind acs_accumulator_stack acs_stack_monitor acs_stack_monitor_inst (.clk(clk), .sys_rst(sys_rst),
  .opValid(opValid), .opCode(opCode), .opLane(opLane), .operand(operand), .scanBit(scanBit),
  .scanInvert(scanInvert), .levelLeave(levelLeave), .statusReq(statusReq), .statusAck(statusAck),
  .statusFlags(statusFlags), .primary_accumulator(primary_accumulator),
  .second_accumulator(second_accumulator), .third_accumulator(third_accumulator),
  .fourth_accumulator(fourth_accumulator), .condition_flag_byte(condition_flag_byte));
